// ===== sched_pkg.sv
// Shared constants for the descriptor schedule map register bank
package sched_pkg;
  // Number of transfer descriptors per category
  localparam int unsigned DESC_COUNT = 32;
  // Index width for one descriptor position
  localparam int unsigned IDX_W = 5;
  // Wishbone data and address widths
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_INT_DONE = 12'h140;
  localparam logic [ADDR_W-1:0] OFS_INT_SKIP = 12'h144;
  localparam logic [ADDR_W-1:0] OFS_INT_FINAL = 12'h148;
  localparam logic [ADDR_W-1:0] OFS_ASYNC_DONE = 12'h150;
  localparam logic [ADDR_W-1:0] OFS_ASYNC_SKIP = 12'h154;
  localparam logic [ADDR_W-1:0] OFS_ASYNC_FINAL = 12'h158;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h160;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h164;
  // Reset values
  localparam logic [DATA_W-1:0] RST_DONE = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_SKIP = 32'hffff_ffff;
  localparam logic [DATA_W-1:0] RST_FINAL = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_IRQ = 32'h0000_0000;
  // Interrupt status and mask field positions
  localparam int unsigned IRQ_INT_DONE_BIT = 0;
  localparam int unsigned IRQ_ASYNC_DONE_BIT = 1;
  localparam int unsigned IRQ_W = 2;
  // Scan engine states
  typedef enum logic [1:0] {
    ST_CHECK = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC = 2'b10
  } scan_state_t;
endpackage

// ===== sched_maps_if.sv
// Carrier between the register bank and one category scanner
`timescale 1ns/10ps
interface sched_maps_if;
  // Skip map, one bit per descriptor
  logic [sched_pkg::DESC_COUNT-1:0] skip_map;
  // Final descriptor map, one marker bit per descriptor
  logic [sched_pkg::DESC_COUNT-1:0] final_map;
  // One-cycle completion pulses, one bit per descriptor
  logic [sched_pkg::DESC_COUNT-1:0] done_set;
  // Register side drives the maps and takes completions
  modport regs (output skip_map, output final_map, input done_set);
  // Scanner side reads the maps and reports completions
  modport scan (input skip_map, input final_map, output done_set);
endinterface

// ===== desc_scanner.sv
// Scanner that walks one category's descriptors under skip and final maps
`timescale 1ns/10ps
module desc_scanner
  import sched_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  sched_maps_if.scan maps,
  output logic [sched_pkg::IDX_W-1:0] idx_o,
  output logic fetch_req_o,
  input wire logic fetch_ack_i,
  input wire logic fetch_valid_i,
  output logic exec_req_o,
  input wire logic exec_done_i
);
  // Current state of the walk
  scan_state_t state_q;
  // Position following the current one
  logic [IDX_W-1:0] next_idx;

  // Wrap to the first descriptor after a final marker or the top slot
  always_comb begin
    if (maps.final_map[idx_o] || idx_o == IDX_W'(DESC_COUNT - 1)) begin
      next_idx = '0;
    end else begin
      next_idx = idx_o + IDX_W'(1);
    end
  end

  // Walk: check skip, fetch header, run the descriptor
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_CHECK;
      idx_o <= '0;
      fetch_req_o <= 1'b0;
      exec_req_o <= 1'b0;
      maps.done_set <= '0;
    end else begin
      maps.done_set <= '0;
      case (state_q)
        ST_CHECK: begin
          // A skipped descriptor is never fetched, whatever its valid flag
          if (maps.skip_map[idx_o]) begin
            idx_o <= next_idx;
          end else begin
            fetch_req_o <= 1'b1;
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          // Header returned: run it only if marked valid
          if (fetch_ack_i) begin
            fetch_req_o <= 1'b0;
            if (fetch_valid_i) begin
              exec_req_o <= 1'b1;
              state_q <= ST_EXEC;
            end else begin
              idx_o <= next_idx;
              state_q <= ST_CHECK;
            end
          end
        end
        ST_EXEC: begin
          // Completion marks the done bit and moves on
          if (exec_done_i) begin
            exec_req_o <= 1'b0;
            maps.done_set <= DESC_COUNT'(1) << idx_o;
            idx_o <= next_idx;
            state_q <= ST_CHECK;
          end
        end
        default: begin
          state_q <= ST_CHECK;
        end
      endcase
    end
  end
endmodule // desc_scanner

// ===== descriptor_schedule_maps.sv
// Register bank of done, skip and final maps with two descriptor scanners
`timescale 1ns/10ps
module descriptor_schedule_maps
  import sched_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic [sched_pkg::ADDR_W-1:0] adr_i,
  input wire logic [sched_pkg::DATA_W-1:0] dat_i,
  output logic [sched_pkg::DATA_W-1:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  // Level interrupt
  output logic irq_o,
  // Periodic-interrupt category engine port
  output logic [sched_pkg::IDX_W-1:0] int_idx_o,
  output logic int_fetch_req_o,
  input wire logic int_fetch_ack_i,
  input wire logic int_fetch_valid_i,
  output logic int_exec_req_o,
  input wire logic int_exec_done_i,
  // Asynchronous category engine port
  output logic [sched_pkg::IDX_W-1:0] async_idx_o,
  output logic async_fetch_req_o,
  input wire logic async_fetch_ack_i,
  input wire logic async_fetch_valid_i,
  output logic async_exec_req_o,
  input wire logic async_exec_done_i
);
  import sched_pkg::*;

  // Map carriers toward each scanner
  sched_maps_if int_maps ();
  sched_maps_if async_maps ();

  // Periodic category maps
  logic [DATA_W-1:0] int_done_q;
  logic [DATA_W-1:0] int_done_d;
  logic [DATA_W-1:0] int_skip_q;
  logic [DATA_W-1:0] int_final_q;

  // Asynchronous category maps
  logic [DATA_W-1:0] async_done_q;
  logic [DATA_W-1:0] async_done_d;
  logic [DATA_W-1:0] async_skip_q;
  logic [DATA_W-1:0] async_final_q;

  // Interrupt status and mask
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_status_d;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_events;

  // Bus request decode
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [DATA_W-1:0] rd_data;

  // Address hit strobes
  logic hit_int_done;
  logic hit_int_skip;
  logic hit_int_final;
  logic hit_async_done;
  logic hit_async_skip;
  logic hit_async_final;
  logic hit_irq_status;
  logic hit_irq_mask;

  // Merge write data into an old value under byte enables
  function automatic logic [DATA_W-1:0] merge_bytes(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] new_val,
    input logic [3:0] sel
  );
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      // Only enabled byte lanes change
      if (sel[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // A request is taken once, in the cycle before ack rises
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign bus_wr = bus_req && we_i;
  assign bus_rd = bus_req && !we_i;

  // Decode of the periodic category offsets
  assign hit_int_done = (adr_i == OFS_INT_DONE);
  assign hit_int_skip = (adr_i == OFS_INT_SKIP);
  assign hit_int_final = (adr_i == OFS_INT_FINAL);

  // Decode of the asynchronous category offsets
  assign hit_async_done = (adr_i == OFS_ASYNC_DONE);
  assign hit_async_skip = (adr_i == OFS_ASYNC_SKIP);
  assign hit_async_final = (adr_i == OFS_ASYNC_FINAL);

  // Decode of the interrupt registers
  assign hit_irq_status = (adr_i == OFS_IRQ_STATUS);
  assign hit_irq_mask = (adr_i == OFS_IRQ_MASK);

  // Maps handed to the scanners
  assign int_maps.skip_map = int_skip_q;
  assign int_maps.final_map = int_final_q;
  assign async_maps.skip_map = async_skip_q;
  assign async_maps.final_map = async_final_q;

  // Per-category completion events for the interrupt logic
  assign irq_events[IRQ_INT_DONE_BIT] = |int_maps.done_set;
  assign irq_events[IRQ_ASYNC_DONE_BIT] = |async_maps.done_set;

  // Periodic done map: clear on read, but a fresh completion survives
  always_comb begin
    int_done_d = int_done_q;
    // Read returns old value and clears every set bit
    if (bus_rd && hit_int_done) begin
      int_done_d = RST_DONE;
    end
    // Set wins over the read clear
    int_done_d = int_done_d | int_maps.done_set;
  end

  // Asynchronous done map: same read-clear with set priority
  always_comb begin
    async_done_d = async_done_q;
    // Read returns old value and clears every set bit
    if (bus_rd && hit_async_done) begin
      async_done_d = RST_DONE;
    end
    // Set wins over the read clear
    async_done_d = async_done_d | async_maps.done_set;
  end

  // Periodic done map: hardware set only, software cannot write it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_done_q <= RST_DONE;
    end else begin
      // Next value already holds the read clear and new completions
      int_done_q <= int_done_d;
    end
  end

  // Asynchronous done map: hardware set only, software cannot write it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      async_done_q <= RST_DONE;
    end else begin
      // Next value already holds the read clear and new completions
      async_done_q <= async_done_d;
    end
  end

  // Periodic skip map: software read/write, every descriptor skipped at reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_skip_q <= RST_SKIP;
    end else begin
      // Only the enabled byte lanes of a write change
      if (bus_wr && hit_int_skip) begin
        int_skip_q <= merge_bytes(int_skip_q, dat_i, sel_i);
      end
    end
  end

  // Asynchronous skip map: software read/write, every descriptor skipped at reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      async_skip_q <= RST_SKIP;
    end else begin
      // Only the enabled byte lanes of a write change
      if (bus_wr && hit_async_skip) begin
        async_skip_q <= merge_bytes(async_skip_q, dat_i, sel_i);
      end
    end
  end

  // Periodic final map: software read/write, no marker at reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_final_q <= RST_FINAL;
    end else begin
      // Only the enabled byte lanes of a write change
      if (bus_wr && hit_int_final) begin
        int_final_q <= merge_bytes(int_final_q, dat_i, sel_i);
      end
    end
  end

  // Asynchronous final map: software read/write, no marker at reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      async_final_q <= RST_FINAL;
    end else begin
      // Only the enabled byte lanes of a write change
      if (bus_wr && hit_async_final) begin
        async_final_q <= merge_bytes(async_final_q, dat_i, sel_i);
      end
    end
  end

  // Interrupt status: sticky, write one to clear, new event wins
  always_comb begin
    irq_status_d = irq_status_q;
    // Write-one-to-clear from software
    if (bus_wr && hit_irq_status && sel_i[0]) begin
      irq_status_d = irq_status_d & ~dat_i[IRQ_W-1:0];
    end
    // Events are never lost to a concurrent clear
    irq_status_d = irq_status_d | irq_events;
  end

  // Interrupt status register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_q <= RST_IRQ[IRQ_W-1:0];
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  // Interrupt mask register, one enable per status bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_q <= RST_IRQ[IRQ_W-1:0];
    end else if (bus_wr && hit_irq_mask && sel_i[0]) begin
      irq_mask_q <= dat_i[IRQ_W-1:0];
    end
  end

  // Level interrupt output, registered from the next status value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_d & irq_mask_q);
    end
  end

  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    rd_data = '0;
    case (1'b1)
      hit_int_done: begin
        rd_data = int_done_q;
      end
      hit_int_skip: begin
        rd_data = int_skip_q;
      end
      hit_int_final: begin
        rd_data = int_final_q;
      end
      hit_async_done: begin
        rd_data = async_done_q;
      end
      hit_async_skip: begin
        rd_data = async_skip_q;
      end
      hit_async_final: begin
        rd_data = async_final_q;
      end
      hit_irq_status: begin
        rd_data = {{(DATA_W-IRQ_W){1'b0}}, irq_status_q};
      end
      hit_irq_mask: begin
        rd_data = {{(DATA_W-IRQ_W){1'b0}}, irq_mask_q};
      end
      default: begin
        rd_data = '0;
      end
    endcase
  end

  // Bus answer: ack one cycle after the request, every address answered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      // A strobe still held while ack is high is not taken twice
      ack_o <= bus_req;
    end
  end

  // Read data register, held until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (bus_rd) begin
      // Captured at the same edge as the read clear
      dat_o <= rd_data;
    end
  end

  // Periodic-interrupt category scanner
  desc_scanner u_int_scan (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .maps(int_maps.scan),
    .idx_o(int_idx_o),
    .fetch_req_o(int_fetch_req_o),
    .fetch_ack_i(int_fetch_ack_i),
    .fetch_valid_i(int_fetch_valid_i),
    .exec_req_o(int_exec_req_o),
    .exec_done_i(int_exec_done_i)
  );

  // Asynchronous category scanner
  desc_scanner u_async_scan (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .maps(async_maps.scan),
    .idx_o(async_idx_o),
    .fetch_req_o(async_fetch_req_o),
    .fetch_ack_i(async_fetch_ack_i),
    .fetch_valid_i(async_fetch_valid_i),
    .exec_req_o(async_exec_req_o),
    .exec_done_i(async_exec_done_i)
  );
endmodule // descriptor_schedule_maps

// ===== sched_props.sv
// Checker for bus handshake and scanner sequencing of the schedule maps
`timescale 1ns/10ps
module sched_props
  import sched_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [sched_pkg::IDX_W-1:0] int_idx_o,
  input wire logic int_fetch_req_o,
  input wire logic int_fetch_ack_i,
  input wire logic int_fetch_valid_i,
  input wire logic int_exec_req_o,
  input wire logic int_exec_done_i,
  input wire logic [sched_pkg::IDX_W-1:0] async_idx_o,
  input wire logic async_fetch_req_o,
  input wire logic async_fetch_ack_i,
  input wire logic async_fetch_valid_i,
  input wire logic async_exec_req_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // New request seen by the slave
  sequence bus_req_s; cyc_i && stb_i && !ack_o; endsequence
  // Header fetched with its valid flag set
  sequence int_go_s; int_fetch_req_o && int_fetch_ack_i && int_fetch_valid_i; endsequence
  sequence async_go_s; async_fetch_req_o && async_fetch_ack_i && async_fetch_valid_i; endsequence
  // Header fetched with its valid flag clear
  sequence async_nogo_s; async_fetch_req_o && async_fetch_ack_i && !async_fetch_valid_i; endsequence
  ack_resp_a: assert property (bus_req_s |=> ack_o)
    else $error("ack missing after request");
  ack_one_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  int_exec_a: assert property (int_go_s |=> int_exec_req_o && !int_fetch_req_o)
    else $error("periodic exec not started");
  async_exec_a: assert property (async_go_s |=> async_exec_req_o && !async_fetch_req_o)
    else $error("async exec not started");
  async_nogo_a: assert property (async_nogo_s |=> !async_exec_req_o)
    else $error("invalid descriptor executed");
  int_hold_a: assert property (int_fetch_req_o && !int_fetch_ack_i
    |=> int_fetch_req_o && $stable(int_idx_o))
    else $error("fetch request dropped early");
  int_done_a: assert property (int_exec_req_o && int_exec_done_i
    |=> !int_exec_req_o ##1 !int_exec_req_o)
    else $error("exec request held after done");
  int_step_a: assert property ($changed(int_idx_o)
    |-> int_idx_o == 5'd0 || int_idx_o == 5'($past(int_idx_o) + 5'd1))
    else $error("periodic index out of order");
  async_step_a: assert property ($changed(async_idx_o)
    |-> async_idx_o == 5'd0 || async_idx_o == 5'($past(async_idx_o) + 5'd1))
    else $error("async index out of order");
endmodule // sched_props
bind descriptor_schedule_maps sched_props sched_props_i (.clk_i, .rst_i, .cyc_i, .stb_i,
  .ack_o, .int_idx_o, .int_fetch_req_o, .int_fetch_ack_i, .int_fetch_valid_i,
  .int_exec_req_o, .int_exec_done_i, .async_idx_o, .async_fetch_req_o,
  .async_fetch_ack_i, .async_fetch_valid_i, .async_exec_req_o);

// ===== descriptor_schedule_maps_tb.sv
// Self-checking bench for the descriptor schedule maps
`timescale 1ns/10ps
module descriptor_schedule_maps_tb;
  import sched_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] adr_i = '0;
  logic [DATA_W-1:0] dat_i = '0;
  logic we_i = 1'b0;
  logic [3:0] sel_i = 4'h0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic [DATA_W-1:0] dat_o;
  logic ack_o, irq_o;
  logic [IDX_W-1:0] int_idx_o, async_idx_o;
  logic int_fetch_req_o, int_exec_req_o, async_fetch_req_o, async_exec_req_o;
  // Engine answers, driven by the stand-in below
  logic int_fetch_ack_i = 1'b0;
  logic int_fetch_valid_i = 1'b1;
  logic int_exec_done_i = 1'b0;
  logic async_fetch_ack_i = 1'b0;
  logic async_fetch_valid_i = 1'b0;
  logic async_exec_done_i = 1'b0;
  logic [31:0] alw [2]; // Descriptors allowed to be fetched
  int cnt0 [2]; // Executions of descriptor 0
  int n_fail = 0;
  int n_compared = 0;
  logic [31:0] rd;

  descriptor_schedule_maps descriptor_schedule_maps_i (.clk_i, .rst_i, .adr_i, .dat_i,
    .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o, .irq_o, .int_idx_o, .int_fetch_req_o,
    .int_fetch_ack_i, .int_fetch_valid_i, .int_exec_req_o, .int_exec_done_i, .async_idx_o,
    .async_fetch_req_o, .async_fetch_ack_i, .async_fetch_valid_i, .async_exec_req_o,
    .async_exec_done_i);

  // Free-running clock, 4 ns period
  always #2 clk_i = ~clk_i;

  // Compare two words and report a mismatch
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    cmp({31'h0, ack_o}, 32'h0000_0001);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    // A bus that never answers ends the run here
    if (ack_o !== 1'b1) begin
      finish_test();
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    wb(1'b0, a, '0);
    cmp(rd, e);
  endtask

  // Let the interrupt settle, then compare it
  task automatic irq_is(input logic e);
    repeat (3) @(posedge clk_i);
    #1;
    cmp({31'h0, irq_o}, {31'h0, e});
  endtask

  task automatic finish_test();
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Engine stand-in: one-cycle answers, async descriptor 1 has its valid flag clear
  always @(posedge clk_i) begin
    int_fetch_ack_i <= int_fetch_req_o && !int_fetch_ack_i;
    int_exec_done_i <= int_exec_req_o && !int_exec_done_i;
    async_fetch_ack_i <= async_fetch_req_o && !async_fetch_ack_i;
    async_fetch_valid_i <= async_idx_o != 5'd1;
    async_exec_done_i <= async_exec_req_o && !async_exec_done_i;
    if (int_fetch_req_o === 1'b1) cmp({31'h0, alw[0][int_idx_o]}, 32'h1);
    if (async_fetch_req_o === 1'b1) cmp({31'h0, alw[1][async_idx_o]}, 32'h1);
    if (int_exec_done_i === 1'b1 && int_idx_o === 5'd0) cnt0[0]++;
    if (async_exec_done_i === 1'b1 && async_idx_o === 5'd0) cnt0[1]++;
  end

  // Hang guard
  initial begin
    #20000;
    n_fail++;
    finish_test();
  end

  // Main sequence
  initial begin
    alw[0] = '0;
    alw[1] = '0;
    cnt0[0] = 0;
    cnt0[1] = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(12'h140, 32'h0000_0000);
    chk(12'h144, 32'hffff_ffff);
    chk(12'h148, 32'h0000_0000);
    chk(12'h150, 32'h0000_0000);
    chk(12'h154, 32'hffff_ffff);
    chk(12'h158, 32'h0000_0000);
    chk(12'h160, 32'h0000_0000);
    chk(12'h164, 32'h0000_0000);
    wr(12'h148, 32'ha5a5_5a5a);
    chk(12'h148, 32'ha5a5_5a5a);
    wr(12'h158, 32'h8000_0001);
    chk(12'h158, 32'h8000_0001);
    wr(12'h140, 32'hffff_ffff);
    chk(12'h140, 32'h0000_0000);
    wr(12'h100, 32'hffff_ffff);
    chk(12'h100, 32'h0000_0000);
    // Periodic uses descriptors 0..1, async uses 0..2
    wr(12'h164, 32'h0000_0003);
    wr(12'h148, 32'h0000_0002);
    wr(12'h158, 32'h0000_0004);
    alw[0] = 32'h0000_0003;
    alw[1] = 32'h0000_0007;
    wr(12'h144, 32'hffff_fffc);
    wr(12'h154, 32'hffff_fff8);
    chk(12'h154, 32'hffff_fff8);
    repeat (300) @(posedge clk_i);
    irq_is(1'b1);
    wr(12'h144, 32'hffff_ffff);
    wr(12'h154, 32'hffff_ffff);
    repeat (20) @(posedge clk_i);
    alw[0] = '0;
    alw[1] = '0;
    chk(12'h140, 32'h0000_0003);
    chk(12'h150, 32'h0000_0005);
    chk(12'h140, 32'h0000_0000);
    chk(12'h150, 32'h0000_0000);
    cmp({31'h0, cnt0[0] > 1}, 32'h1);
    cmp({31'h0, cnt0[1] > 1}, 32'h1);
    // Value 3 in the periodic final map wraps the scan back to descriptor 0 at descriptor 0
    alw[0] = 32'h0000_0001;
    wr(12'h148, 32'h0000_0003);
    wr(12'h144, 32'hffff_fffc);
    repeat (50) @(posedge clk_i);
    wr(12'h144, 32'hffff_ffff);
    repeat (20) @(posedge clk_i);
    alw[0] = '0;
    chk(12'h140, 32'h0000_0001);
    chk(12'h160, 32'h0000_0003);
    wr(12'h164, 32'h0000_0000);
    irq_is(1'b0);
    wr(12'h164, 32'h0000_0001);
    irq_is(1'b1);
    wr(12'h160, 32'h0000_0003);
    irq_is(1'b0);
    chk(12'h160, 32'h0000_0000);
    finish_test();
  end
endmodule // descriptor_schedule_maps_tb
